// ---- hw/lcd_display.v ----
// charge-level led bar-graph controller with axi4-lite control registers
//
// Summary of operation
// [RULE1] Drive three, four or five leds; control bits pick the count.
// [RULE2] Relative mode scales to full charge capacity, absolute to design capacity.
// [RULE3] A scale select control bit chooses absolute or relative display mode.
// [RULE4] Falling edge on the request input shows the display for four seconds.
// [RULE5] Next activation needs input high then low, only after the timer expired.
// [RULE6] While end-of-discharge flag is set, every led stays off.
// [RULE7] Each lit led represents 20, 25 or 33 percent of charge.
// [RULE8] Lit leds blink while remaining capacity is below the alarm level.
// [RULE9] Five leds: thresholds at 20, 40, 60 and 80 percent.
// [RULE10] Four leds: thresholds at 25, 50 and 75 percent.
// [RULE11] Three leds: thresholds at 34 and 67 percent.
// [RULE12] Request input synchronised before edge detection; leds off when timer expires.
// [RULE13] Blink toggles about every half second, set by a parameter.
`timescale 1ns/100ps
`include "lcd_map.vh"

module lcd_display #(
  parameter [31:0] SHOW_CYCLES = `LCD_SHOW_TIME_MS * 1000 * `LCD_CLK_MHZ,
  parameter [31:0] BLINK_CYCLES = `LCD_BLINK_HALF_MS * 1000 * `LCD_CLK_MHZ
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // pushbutton pin
  input wire display_request_input,
  // gauge core values
  input wire [15:0] full_charge_capacity,
  input wire [15:0] design_capacity,
  input wire [15:0] remaining_capacity,
  input wire [15:0] remaining_capacity_alarm,
  input wire end_of_discharge_flag,
  // led bar-graph, bit 0 is led1, high lights the led
  output reg [4:0] led_drive,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

// display states
localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_SHOW = 2'b10;

// control register
reg [1:0] led_count_sel;
reg display_scale_select;

// write channel holding
reg aw_held;
reg w_held;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;

// request pin synchroniser and edge detect
reg req_meta;
reg req_sync;
reg req_prev;
wire req_fall;

// display state and timers
reg [1:0] state;
reg [1:0] next_state;
reg [31:0] show_cnt;
reg [31:0] blink_cnt;
reg blink_phase;

// charge percentage
reg [7:0] soc_pct;
wire div_busy;
wire div_done;
wire [7:0] div_pct;
wire [15:0] reference;
wire below_alarm;
wire [4:0] lit;
wire [4:0] next_led;
wire [2:0] level;

// thermometer level for a percentage and led option
function [2:0] bar_level;
  input [7:0] pct;
  input [1:0] sel;
  begin
    case (sel)
      `LCD_CNT_THREE:
        bar_level = 3'h1 + {2'h0, pct >= `LCD_P3_1} + {2'h0, pct >= `LCD_P3_2}; // RULE11
      `LCD_CNT_FOUR:
        bar_level = 3'h1 + {2'h0, pct >= `LCD_P4_1} + {2'h0, pct >= `LCD_P4_2}
          + {2'h0, pct >= `LCD_P4_3}; // RULE10
      default:
        bar_level = 3'h1 + {2'h0, pct >= `LCD_P5_1} + {2'h0, pct >= `LCD_P5_2}
          + {2'h0, pct >= `LCD_P5_3} + {2'h0, pct >= `LCD_P5_4}; // RULE9
    endcase
  end
endfunction

// register address match, used by both read and write paths
function is_ctrl;
  input [7:0] addr;
  begin
    is_ctrl = ({addr[7:2], 2'b00} == `LCD_REG_CTRL);
  end
endfunction

// reference capacity chosen by the scale mode
assign reference = display_scale_select ? design_capacity : full_charge_capacity; // RULE2 RULE3

// percentage divider, restarted whenever idle
lcd_soc_div u_div (
  .sys_clk(sys_clk),
  .rst(rst),
  .start(!div_busy),
  .numer(remaining_capacity),
  .denom(reference),
  .busy(div_busy),
  .done(div_done),
  .percent(div_pct)
);

// latest percentage result
always @(posedge sys_clk or posedge rst)
begin
  if (rst)
    soc_pct <= 8'h00;
  else if (div_done)
    soc_pct <= div_pct;
end

// two-stage synchroniser then edge detect on the request pin
always @(posedge sys_clk or posedge rst)
begin
  if (rst)
  begin
    req_meta <= 1'b0;
    req_sync <= 1'b0;
    req_prev <= 1'b0;
  end
  else
  begin
    req_meta <= display_request_input; // RULE12
    req_sync <= req_meta;
    req_prev <= req_sync;
  end
end

assign req_fall = req_prev & ~req_sync; // RULE12

// display state machine: a falling edge only counts while idle
always @*
begin
  next_state = state;
  case (state)
    ST_IDLE:
      if (req_fall)
        next_state = ST_SHOW; // RULE4 RULE5
    ST_SHOW:
      if (show_cnt == 32'h00000001)
        next_state = ST_IDLE; // RULE12
    default:
      next_state = ST_IDLE;
  endcase
end

// state register and show timer
always @(posedge sys_clk or posedge rst)
begin
  if (rst)
  begin
    state <= ST_IDLE;
    show_cnt <= 32'h00000000;
  end
  else
  begin
    state <= next_state;
    if (state == ST_IDLE && req_fall)
      show_cnt <= SHOW_CYCLES; // RULE4
    else if (show_cnt != 32'h00000000)
      show_cnt <= show_cnt - 32'h00000001;
  end
end

// blink phase, restarted lit at each activation
always @(posedge sys_clk or posedge rst)
begin
  if (rst)
  begin
    blink_cnt <= 32'h00000000;
    blink_phase <= 1'b1;
  end
  else if (state != ST_SHOW)
  begin
    blink_cnt <= 32'h00000000;
    blink_phase <= 1'b1;
  end
  else if (blink_cnt >= BLINK_CYCLES - 32'h00000001)
  begin
    blink_cnt <= 32'h00000000;
    blink_phase <= ~blink_phase; // RULE13
  end
  else
    blink_cnt <= blink_cnt + 32'h00000001;
end

assign below_alarm = remaining_capacity < remaining_capacity_alarm; // RULE8
assign level = bar_level(soc_pct, led_count_sel); // RULE7

// thermometer code, one led per step of charge
genvar gi;
generate
  for (gi = 0; gi < 5; gi = gi + 1)
  begin : g_bar
    assign lit[gi] = level > gi; // RULE1
  end
endgenerate

// gating: shown, not discharged, and not below alarm or blink phase on
assign next_led = (state == ST_SHOW && !end_of_discharge_flag // RULE6
  && (!below_alarm || blink_phase)) ? lit : 5'h00; // RULE8

// led outputs registered
always @(posedge sys_clk or posedge rst)
begin
  if (rst)
    led_drive <= 5'h00;
  else
    led_drive <= next_led;
end

// write address and data taken in either order, one write at a time
always @(posedge sys_clk or posedge rst)
begin
  if (rst)
  begin
    aw_held <= 1'b0;
    w_held <= 1'b0;
    aw_addr <= 8'h00;
    w_data <= 32'h00000000;
    w_strb <= 4'h0;
    s_axi_awready <= 1'b0;
    s_axi_wready <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `LCD_RESP_OKAY;
    {display_scale_select, led_count_sel} <= `LCD_CTRL_RESET;
  end
  else
  begin
    s_axi_awready <= 1'b0;
    s_axi_wready <= 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (!aw_held && !s_axi_bvalid && s_axi_awvalid)
      s_axi_awready <= 1'b1;
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (!w_held && !s_axi_bvalid && s_axi_wvalid)
      s_axi_wready <= 1'b1;
    if (aw_held && w_held && !s_axi_bvalid)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_bvalid <= 1'b1;
      if (is_ctrl(aw_addr))
      begin
        s_axi_bresp <= `LCD_RESP_OKAY;
        if (w_strb[0])
        begin
          led_count_sel <= w_data[`LCD_CTRL_CNT_HI:`LCD_CTRL_CNT_LO]; // RULE1
          display_scale_select <= w_data[`LCD_CTRL_SCALE_BIT]; // RULE3
        end
      end
      else
        s_axi_bresp <= `LCD_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
end

// read channel: one cycle to take the address, next cycle data
always @(posedge sys_clk or posedge rst)
begin
  if (rst)
  begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= `LCD_RESP_OKAY;
  end
  else
  begin
    s_axi_arready <= 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LCD_RESP_OKAY;
      if (is_ctrl(s_axi_araddr))
      begin
        s_axi_rdata[`LCD_CTRL_CNT_HI:`LCD_CTRL_CNT_LO] <= led_count_sel;
        s_axi_rdata[`LCD_CTRL_SCALE_BIT] <= display_scale_select;
      end
      else if ({s_axi_araddr[7:2], 2'b00} == `LCD_REG_STATUS)
      begin
        s_axi_rdata[`LCD_ST_LED_HI:`LCD_ST_LED_LO] <= led_drive;
        s_axi_rdata[`LCD_ST_SHOW_BIT] <= (state == ST_SHOW);
        s_axi_rdata[`LCD_ST_BLINK_BIT] <= below_alarm;
        s_axi_rdata[`LCD_ST_EOD_BIT] <= end_of_discharge_flag;
        s_axi_rdata[`LCD_ST_PHASE_BIT] <= blink_phase;
      end
      else if ({s_axi_araddr[7:2], 2'b00} == `LCD_REG_SOC)
        s_axi_rdata[7:0] <= soc_pct;
      else
        s_axi_rresp <= `LCD_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid && s_axi_arvalid)
      s_axi_arready <= 1'b1;
  end
end

endmodule // lcd_display

// ---- hw/lcd_map.vh ----
// constants for the charge-level bar-graph display block
`ifndef LCD_MAP_VH
`define LCD_MAP_VH

// clock rate and display timings
`define LCD_CLK_MHZ 250
`define LCD_SHOW_TIME_MS 4000
`define LCD_BLINK_HALF_MS 500

// register byte addresses
`define LCD_REG_CTRL 8'h00
`define LCD_REG_STATUS 8'h04
`define LCD_REG_SOC 8'h08

// control register fields and reset value
`define LCD_CTRL_CNT_LO 0
`define LCD_CTRL_CNT_HI 1
`define LCD_CTRL_SCALE_BIT 2
`define LCD_CTRL_RESET 3'h2

// led count selections
`define LCD_CNT_THREE 2'h0
`define LCD_CNT_FOUR 2'h1
`define LCD_CNT_FIVE 2'h2

// status register fields
`define LCD_ST_LED_LO 0
`define LCD_ST_LED_HI 4
`define LCD_ST_SHOW_BIT 8
`define LCD_ST_BLINK_BIT 9
`define LCD_ST_EOD_BIT 10
`define LCD_ST_PHASE_BIT 11

// axi responses
`define LCD_RESP_OKAY 2'h0
`define LCD_RESP_SLVERR 2'h2

// percentage thresholds per led option
`define LCD_P5_1 8'h14
`define LCD_P5_2 8'h28
`define LCD_P5_3 8'h3C
`define LCD_P5_4 8'h50
`define LCD_P4_1 8'h19
`define LCD_P4_2 8'h32
`define LCD_P4_3 8'h4B
`define LCD_P3_1 8'h22
`define LCD_P3_2 8'h43

// percentage scaling
`define LCD_PCT_FULL 8'h64
`define LCD_PCT_MUL 7'h64
`define LCD_DIV_STEPS 5'h17

`endif

// ---- hw/lcd_soc_div.v ----
// sequential divider giving remaining capacity as a percentage of a reference
`timescale 1ns/100ps
`include "lcd_map.vh"

module lcd_soc_div (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // request
  input wire start,
  input wire [15:0] numer,
  input wire [15:0] denom,
  // result
  output reg busy,
  output reg done,
  output reg [7:0] percent
);

reg [22:0] dividend;
reg [22:0] quot;
reg [16:0] rem;
reg [15:0] den_hold;
reg [4:0] steps;
wire [16:0] trial;
wire [22:0] scaled;

assign scaled = numer * `LCD_PCT_MUL;
assign trial = {rem[15:0], dividend[22]};

// one quotient bit per cycle, result clamped to full scale
always @(posedge sys_clk or posedge rst)
begin
  if (rst)
  begin
    busy <= 1'b0;
    done <= 1'b0;
    percent <= 8'h00;
    dividend <= 23'h000000;
    quot <= 23'h000000;
    rem <= 17'h00000;
    den_hold <= 16'h0000;
    steps <= 5'h00;
  end
  else
  begin
    done <= 1'b0;
    if (!busy)
    begin
      if (start)
      begin
        busy <= 1'b1;
        dividend <= scaled;
        den_hold <= denom;
        quot <= 23'h000000;
        rem <= 17'h00000;
        steps <= `LCD_DIV_STEPS;
      end
    end
    else if (steps != 5'h00)
    begin
      dividend <= {dividend[21:0], 1'b0};
      steps <= steps - 5'h01;
      if (trial >= {1'b0, den_hold})
      begin
        rem <= trial - {1'b0, den_hold};
        quot <= {quot[21:0], 1'b1};
      end
      else
      begin
        rem <= trial;
        quot <= {quot[21:0], 1'b0};
      end
    end
    else
    begin
      busy <= 1'b0;
      done <= 1'b1;
      if (den_hold == 16'h0000)
        percent <= 8'h00; // no reference, show empty
      else if (quot >= {15'h0000, `LCD_PCT_FULL})
        percent <= `LCD_PCT_FULL;
      else
        percent <= quot[7:0];
    end
  end
end

endmodule // lcd_soc_div

// ---- testbench/lcd_button.sv ----
// pushbutton with pull-up feeding the display request pin
`timescale 1ns/100ps
module lcd_button (
  // push from the bench
  input wire press,
  // pin seen by the block
  output wire display_request_input
);
  // closed switch pulls low, open leaves the pull-up
  assign display_request_input = press ? 1'b0 : 1'b1;
endmodule // lcd_button

// ---- testbench/lcd_display_props.sv ----
// assertions on the charge-level display block ports
`timescale 1ns/100ps
module lcd_display_props #(
  parameter [31:0] SHOW_CYCLES = 32'hC8
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // pin and gauge values
  input wire display_request_input,
  input wire [15:0] remaining_capacity,
  input wire [15:0] remaining_capacity_alarm,
  input wire end_of_discharge_flag,
  input wire [4:0] led_drive,
  // register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  reg [31:0] run;
  wire lit = |led_drive;
  // neither blink nor discharge mask in force
  wire calm = !end_of_discharge_flag && remaining_capacity >= remaining_capacity_alarm;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // cycles the bar has stayed lit
  always @(posedge sys_clk or posedge rst)
    if (rst)
      run <= 32'h0;
    else
      run <= lit ? run + 32'h1 : 32'h0;
  property p_eod; end_of_discharge_flag && $past(end_of_discharge_flag) |-> !lit; endproperty
  a_eod: assert property (p_eod) else $error("leds lit at end of discharge");
  property p_bar; led_drive inside {5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F}; endproperty
  a_bar: assert property (p_bar) else $error("leds not a bar");
  property p_act; $fell(display_request_input) && calm |-> ##[2:6] lit; endproperty
  a_act: assert property (p_act) else $error("press did not light");
  property p_max; lit |-> run < SHOW_CYCLES + 32'h2; endproperty
  a_max: assert property (p_max) else $error("display outlived timer");
  property p_min; $fell(lit) && calm |-> run >= SHOW_CYCLES - 32'h3; endproperty
  a_min: assert property (p_min) else $error("display ended early");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_blat; s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
  a_blat: assert property (p_blat) else $error("write response late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read data late");
  c_show: cover property ($fell(lit) && calm);
  c_blink: cover property ($fell(lit) && !calm);
  c_bwait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule // lcd_display_props

bind lcd_display lcd_display_props #(.SHOW_CYCLES(SHOW_CYCLES)) lcd_display_props_inst (
  .sys_clk, .rst, .display_request_input, .remaining_capacity, .remaining_capacity_alarm,
  .end_of_discharge_flag, .led_drive, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready
);

// ---- testbench/tb.sv ----
// self-checking bench for the charge-level display block
`timescale 1ns/100ps
module tb;
  localparam [31:0] SHOW = 32'hC8;
  localparam [143:0] BND = {16'h13, 16'h14, 16'h22, 16'h31, 16'h32, 16'h43, 16'h4B, 16'h50,
    16'h12C};
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg press = 1'b0;
  reg end_of_discharge_flag = 1'b0;
  reg [15:0] full_charge_capacity = 16'h64;
  reg [15:0] design_capacity = 16'hC8;
  reg [15:0] remaining_capacity = 16'h0;
  reg [15:0] remaining_capacity_alarm = 16'h0;
  reg [7:0] s_axi_awaddr = 8'h0;
  reg [7:0] s_axi_araddr = 8'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire display_request_input, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [4:0] led_drive;
  integer errors = 0, cmp_count = 0, cyc = 0, c, k, v, p, sc, n, m;

  lcd_button lcd_button_inst (.press, .display_request_input);
  lcd_display #(.SHOW_CYCLES(SHOW), .BLINK_CYCLES(32'h14)) lcd_display_inst (
    .sys_clk, .rst, .display_request_input, .full_charge_capacity, .design_capacity,
    .remaining_capacity, .remaining_capacity_alarm, .end_of_discharge_flag, .led_drive,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  always #2 sys_clk = ~sys_clk;

  // hang guard
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      errors = errors + 1;
      test_done;
    end
  end

  task check(input [31:0] s, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e)
      begin
        errors = errors + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask

  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // model: thermometer bar from percent and led count
  function [4:0] exp_leds(input integer cs, input integer pc);
    integer t;
    begin
      if (cs == 0)
        t = 1 + (pc >= 34) + (pc >= 67);
      else if (cs == 1)
        t = 1 + (pc >= 25) + (pc >= 50) + (pc >= 75);
      else
        t = 1 + (pc >= 20) + (pc >= 40) + (pc >= 60) + (pc >= 80);
      exp_leds = (5'h01 << t) - 5'h01;
    end
  endfunction

  // bus write, address and data offered together, late bready
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      m = 0;
      while (m != 3)
      begin
        @(posedge sys_clk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
        m = m | {s_axi_wready, s_axi_awready};
      end
      repeat ($urandom % 3) @(posedge sys_clk);
      s_axi_bready <= 1'b1;
      @(posedge sys_clk);
      while (!s_axi_bvalid) @(posedge sys_clk);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, r});
    end
  endtask

  // bus read with late rready
  task rd(input [7:0] a, input [31:0] d, input [1:0] r);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge sys_clk);
      while (!s_axi_arready) @(posedge sys_clk);
      s_axi_arvalid <= 1'b0;
      repeat ($urandom % 3) @(posedge sys_clk);
      s_axi_rready <= 1'b1;
      @(posedge sys_clk);
      while (!s_axi_rvalid) @(posedge sys_clk);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, d);
      check({30'h0, s_axi_rresp}, {30'h0, r});
    end
  endtask

  // press, check bar, re-press mid-show, timer must not restart
  task show(input [4:0] e);
    begin
      press <= 1'b1;
      repeat (8) @(posedge sys_clk);
      check(led_drive, e);
      press <= 1'b0;
      repeat (20) @(posedge sys_clk);
      press <= 1'b1;
      n = 0;
      while (led_drive !== 5'h00 && n < 400)
      begin
        @(posedge sys_clk);
        n = n + 1;
      end
      check(n > 150 && n < 185, 1);
      repeat (30) @(posedge sys_clk);
      check(led_drive, 5'h00);
      press <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask

  initial
  begin
    v = $urandom(32'hC935A05E);
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h00, 32'h2, 2'h0);
    rd(8'h0C, 32'h0, 2'h2);
    rd(8'h04, 32'h800, 2'h0);
    wr(8'h04, 32'h7, 2'h2);
    rd(8'h00, 32'h2, 2'h0);
    $display("test registers done");
    for (c = 0; c < 3; c = c + 1)
      for (k = 0; k < 10; k = k + 1)
      begin
        sc = $urandom % 2;
        v = (k < 9) ? BND[k * 16 +: 16] : $urandom % 300;
        p = v * 100 / (sc ? 200 : 100);
        if (p > 100)
          p = 100;
        remaining_capacity <= v[15:0];
        wr(8'h00, (sc << 2) | c, 2'h0);
        repeat (60) @(posedge sys_clk);
        rd(8'h08, p, 2'h0);
        show(exp_leds(c, p));
      end
    $display("test levels done");
    end_of_discharge_flag <= 1'b1;
    press <= 1'b1;
    repeat (30) @(posedge sys_clk);
    check(led_drive, 5'h00);
    press <= 1'b0;
    repeat (240) @(posedge sys_clk);
    rd(8'h04, 32'hC00, 2'h0);
    end_of_discharge_flag <= 1'b0;
    $display("test discharge done");
    remaining_capacity_alarm <= 16'hFFFF;
    press <= 1'b1;
    n = 0;
    repeat (180)
    begin
      @(posedge sys_clk);
      n = n + (led_drive == 5'h00);
    end
    check(n > 40 && n < 140, 1);
    press <= 1'b0;
    repeat (60) @(posedge sys_clk);
    remaining_capacity_alarm <= 16'h0;
    $display("test blink done");
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h00, 32'h2, 2'h0);
    $display("test reset done");
    test_done;
  end
endmodule // tb
